// ---- mono_packer_defs.vh ----
// Purpose: Shared constants for the monochrome pixel packer
// Assumes: Included by bare name from design files
// Notes:   Format codes match the two-bit format select input
`ifndef MONO_PACKER_DEFS_VH
`define MONO_PACKER_DEFS_VH

`define FMT_MONO8        2'h0
`define FMT_MONO12       2'h1
`define FMT_MONO12_PACK  2'h2
`define FMT_RESET        2'h0

`define PIX_W            12
`define BYTE_W           8
`define FIFO_DEPTH       4
`define FIFO_AW          2

`endif

// ---- byte_fifo.v ----
// Purpose: Small flip-flop FIFO between packer and byte transmitter
// Assumes: Synchronous active-low reset, single clock
// Notes:   Outputs registered; depth must be a power of two
`timescale 1ns/1ps
module byte_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk_sys,
    input  wire             rstn,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output reg              in_ready,
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr;
    reg  [AW-1:0]    rd_ptr;
    reg  [AW:0]      count;
    wire             push = in_valid & in_ready;
    wire             pop  = out_valid & out_ready;
    wire [AW:0]      next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    wire [AW-1:0]    next_rd = pop ? rd_ptr + 1'b1 : rd_ptr;
    integer i;

    always @(posedge clk_sys) begin
        if (!rstn) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= wr_ptr + 1'b1;
            end
            rd_ptr    <= next_rd;
            count     <= next_count;
            // Full check uses next count so ready never overstates room
            in_ready  <= (next_count < DEPTH);
            out_valid <= (next_count != {(AW+1){1'b0}});
            // Write-through when the slot being presented is written now
            if (push && (wr_ptr == next_rd))
                out_data <= in_data;
            else
                out_data <= mem[next_rd];
        end
    end

endmodule

// ---- mono_pixel_format_packer.v ----
// Purpose: Pack 12-bit mono samples into host byte stream formats
// Assumes: Pixel source holds data while pix_ready is low
// Notes:   Format change takes effect at the next frame start
//
// Contract
// - Eight-bit format: one byte per pixel
// - Bytes leave strictly in pixel order
// - Eight-bit byte maps directly to level 0..255
// - Unpacked twelve-bit: one 16-bit word per pixel
// - Unpacked: right-aligned, upper four bits zero
// - Unpacked: low byte first, then bits 11..8
// - Unpacked word never exceeds 0x0fff
// - Packed: two pixels in three bytes
// - Packed order: even high, nibbles, odd high
// - Packed pixel values stay 0 to 0x0fff
`timescale 1ns/1ps
`include "mono_packer_defs.vh"
module mono_pixel_format_packer (
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire [1:0]  format_sel,
    input  wire [11:0] pix_data,
    input  wire        pix_valid,
    input  wire        pix_sof,
    input  wire        pix_eof,
    output reg         pix_ready,
    output reg  [7:0]  tx_data,
    output reg         tx_last,
    output reg         tx_valid,
    input  wire        tx_ready,
    output reg  [1:0]  active_format
);
    localparam ST_TAKE  = 2'h0;
    localparam ST_BYTE1 = 2'h1;
    localparam ST_BYTE2 = 2'h2;

    reg  [1:0]  state;
    reg  [11:0] even_pix;
    reg  [11:0] odd_pix;
    reg         pair_half;
    reg         hold_last;
    reg  [8:0]  push_word;
    reg         push_valid;
    wire        fifo_in_ready;
    wire [8:0]  fifo_out_data;
    wire        fifo_out_valid;

    reg  [1:0]  next_state;
    reg  [1:0]  next_format;
    reg  [8:0]  next_push_word;
    reg         next_push_valid;
    reg         next_pix_ready;
    reg  [11:0] next_even;
    reg  [11:0] next_odd;
    reg         next_half;
    reg         next_hold_last;
    reg  [1:0]  use_format;
    wire        take = pix_valid & pix_ready;
    wire        stage_free = ~push_valid | fifo_in_ready;

    always @* begin
        next_state      = state;
        next_format     = active_format;
        next_push_word  = push_word;
        next_push_valid = push_valid & ~fifo_in_ready;
        next_even       = even_pix;
        next_odd        = odd_pix;
        next_half       = pair_half;
        next_hold_last  = hold_last;
        use_format      = active_format;
        if (take && pix_sof) begin
            // Latch the new format with the first pixel of a frame
            use_format  = (format_sel == 2'h3) ? `FMT_MONO8 : format_sel;
            next_format = use_format;
            next_half   = 1'b0;
        end
        case (state)
            ST_TAKE: begin
                if (take) begin
                    case (use_format)
                        `FMT_MONO12: begin
                            // Low byte first of zero-padded word
                            next_push_word  = {1'b0, pix_data[7:0]};
                            next_push_valid = 1'b1;
                            next_even       = pix_data;
                            next_hold_last  = pix_eof;
                            next_state      = ST_BYTE1;
                        end
                        `FMT_MONO12_PACK: begin
                            if (!next_half) begin
                                // Even pixel high bits go out at once
                                next_push_word  = {1'b0, pix_data[11:4]};
                                next_push_valid = 1'b1;
                                next_even       = pix_data;
                                next_half       = 1'b1;
                                // Odd-length frame: pad odd pixel with zero
                                if (pix_eof) begin
                                    next_odd       = 12'h000;
                                    next_hold_last = 1'b1;
                                    next_half      = 1'b0;
                                    next_state     = ST_BYTE1;
                                end
                            end else begin
                                next_odd        = pix_data;
                                next_push_word  = {1'b0, pix_data[3:0], even_pix[3:0]};
                                next_push_valid = 1'b1;
                                next_hold_last  = pix_eof;
                                next_half       = 1'b0;
                                next_state      = ST_BYTE2;
                            end
                        end
                        default: begin
                            // One byte, straight 0..255 level
                            next_push_word  = {pix_eof, pix_data[7:0]};
                            next_push_valid = 1'b1;
                        end
                    endcase
                end
            end
            ST_BYTE1: begin
                if (stage_free) begin
                    next_push_valid = 1'b1;
                    if (active_format == `FMT_MONO12) begin
                        // Upper nibble forced zero keeps word at most 0x0fff
                        next_push_word = {hold_last, 4'h0, even_pix[11:8]};
                        next_state     = ST_TAKE;
                    end else begin
                        next_push_word = {1'b0, odd_pix[3:0], even_pix[3:0]};
                        next_state     = ST_BYTE2;
                    end
                end
            end
            ST_BYTE2: begin
                if (stage_free) begin
                    // Twelve bits only, so values stay within range
                    next_push_word  = {hold_last, odd_pix[11:4]};
                    next_push_valid = 1'b1;
                    next_state      = ST_TAKE;
                end
            end
            default: next_state = ST_TAKE;
        endcase
        // Accept a pixel only when the single stage can hand off
        next_pix_ready = (next_state == ST_TAKE) && (~next_push_valid | ~push_valid)
                         && fifo_in_ready;
    end

    always @(posedge clk_sys) begin
        if (!rstn) begin
            state         <= ST_TAKE;
            active_format <= `FMT_RESET;
            push_word     <= 9'h000;
            push_valid    <= 1'b0;
            pix_ready     <= 1'b0;
            even_pix      <= 12'h000;
            odd_pix       <= 12'h000;
            pair_half     <= 1'b0;
            hold_last     <= 1'b0;
            tx_data       <= 8'h00;
            tx_last       <= 1'b0;
            tx_valid      <= 1'b0;
        end else begin
            state         <= next_state;
            active_format <= next_format;
            push_word     <= next_push_word;
            push_valid    <= next_push_valid;
            pix_ready     <= next_pix_ready;
            even_pix      <= next_even;
            odd_pix       <= next_odd;
            pair_half     <= next_half;
            hold_last     <= next_hold_last;
            // Output register drains FIFO; holds while sink stalls
            if (!tx_valid || tx_ready) begin
                tx_valid <= fifo_out_valid;
                tx_data  <= fifo_out_data[7:0];
                tx_last  <= fifo_out_data[8];
            end
        end
    end

    wire fifo_pop = ~tx_valid | tx_ready;

    // FIFO keeps byte order intact under sink back-pressure
    byte_fifo #(
        .WIDTH (9),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_data   (push_word),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );
endmodule

// ---- mono_pixel_format_packer_assertions.sv ----
// Purpose: Port-level checks for the mono packer
// Assumes: Each frame drains before the next one starts
// Notes:   Byte phase is counted from accepted bytes
`timescale 1ns/1ps
module mono_packer_checker (
    input wire       clk_sys,
    input wire       rstn,
    input wire       pix_valid,
    input wire       pix_sof,
    input wire       pix_ready,
    input wire [7:0] tx_data,
    input wire       tx_last,
    input wire       tx_valid,
    input wire       tx_ready,
    input wire [1:0] active_format
);
    wire      take = tx_valid && tx_ready;
    reg       par;
    reg [1:0] ph;
    always @(posedge clk_sys) begin
        if (!rstn || (take && tx_last)) begin
            par <= 1'b0;
            ph  <= 2'h0;
        end else if (take) begin
            par <= ~par;
            ph  <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_stall;
        tx_valid && !tx_ready;
    endsequence
    a_hold_stalled: assert property (s_stall |=> tx_valid && $stable(tx_data)
        && $stable(tx_last)) else $error("byte changed while stalled");
    a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !tx_valid && !pix_ready)
        else $error("outputs active after reset");
    a_reset_format: assert property (disable iff (1'b0) !rstn |=> active_format == 2'h0)
        else $error("format not mono8 after reset");
    a_format_frame: assert property (!(pix_valid && pix_ready && pix_sof)
        |=> $stable(active_format)) else $error("format changed inside frame");
    a_format_legal: assert property (active_format != 2'h3)
        else $error("illegal format in force");
    a_upper_zero: assert property (active_format == 2'h1 && tx_valid && par
        |-> tx_data[7:4] == 4'h0) else $error("upper bits not zero");
    a_word_whole: assert property (take && tx_last && active_format == 2'h1 |-> par)
        else $error("frame ended inside a word");
    a_pair_whole: assert property (take && tx_last && active_format == 2'h2
        |-> ph == 2'h2) else $error("frame ended inside a pair");
endmodule
bind mono_pixel_format_packer mono_packer_checker chk_i (.clk_sys(clk_sys), .rstn(rstn),
    .pix_valid(pix_valid), .pix_sof(pix_sof), .pix_ready(pix_ready), .tx_data(tx_data),
    .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .active_format(active_format));

// ---- byte_sink.sv ----
// Purpose: Host-side byte sink model
// Assumes: Seed is set by the bench
// Notes:   Random readiness plus a hold input for long stalls
`timescale 1ns/1ps
module byte_sink (
    input  wire       clk_sys,
    input  wire       rstn,
    input  wire [7:0] tx_data,
    input  wire       tx_last,
    input  wire       tx_valid,
    input  wire       hold,
    output reg        tx_ready
);
    logic [8:0] got [$];
    // Ready is only driven here; reset clears it on the first edge
    always @(posedge clk_sys) begin
        if (rstn && tx_valid && tx_ready) got.push_back({tx_last, tx_data});
        tx_ready <= rstn && !hold && ($urandom % 3 != 0);
    end
endmodule

// ---- mono_pixel_format_packer_tb.sv ----
// Purpose: Self-checking bench for the mono packer
// Assumes: One frame in flight at a time
// Notes:   Format select is scrambled mid-frame on purpose
`timescale 1ns/1ps
module mono_pixel_format_packer_tb;
    logic        clk_sys, rstn, pix_valid, pix_sof, pix_eof, hold;
    logic [1:0]  format_sel;
    logic [11:0] pix_data;
    wire         pix_ready, tx_last, tx_valid, tx_ready;
    wire  [7:0]  tx_data;
    wire  [1:0]  active_format;
    logic [11:0] px [0:63];
    logic [7:0]  exp_q [$];
    int          fails, n_compared, cyc;
    mono_pixel_format_packer mono_pixel_format_packer_i (.clk_sys(clk_sys), .rstn(rstn),
        .format_sel(format_sel), .pix_data(pix_data), .pix_valid(pix_valid),
        .pix_sof(pix_sof), .pix_eof(pix_eof), .pix_ready(pix_ready), .tx_data(tx_data),
        .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .active_format(active_format));
    byte_sink byte_sink_i (.clk_sys(clk_sys), .rstn(rstn), .tx_data(tx_data),
        .tx_last(tx_last), .tx_valid(tx_valid), .hold(hold), .tx_ready(tx_ready));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task give_verdict;
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            give_verdict;
        end
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Code 3 falls back to one byte per pixel; odd packed frames pad with zero
    function automatic void build(input logic [1:0] f, input int n);
        logic [11:0] b;
        exp_q.delete();
        for (int i = 0; i < n; i++) begin
            if (f == 2'h1) begin
                exp_q.push_back(px[i][7:0]);
                exp_q.push_back({4'h0, px[i][11:8]});
            end else if (f == 2'h2) begin
                if (i % 2 == 0) begin
                    b = (i + 1 < n) ? px[i + 1] : 12'h000;
                    exp_q.push_back(px[i][11:4]);
                    exp_q.push_back({b[3:0], px[i][3:0]});
                    exp_q.push_back(b[11:4]);
                end
            end else begin
                exp_q.push_back(px[i][7:0]);
            end
        end
    endfunction
    task automatic run(input logic [1:0] f, input int n, input int hc);
        int w;
        build(f, n);
        byte_sink_i.got.delete();
        hold <= (hc > 0);
        fork
            begin
                repeat (hc) @(posedge clk_sys);
                hold <= 1'b0;
            end
        join_none
        for (int i = 0; i < n; i++) begin
            format_sel <= (i == 0) ? f : 2'($urandom);
            pix_data   <= px[i];
            pix_valid  <= 1'b1;
            pix_sof    <= (i == 0);
            pix_eof    <= (i == n - 1);
            @(posedge clk_sys);
            while (pix_ready !== 1'b1) @(posedge clk_sys);
        end
        pix_valid <= 1'b0;
        pix_sof   <= 1'b0;
        pix_eof   <= 1'b0;
        w = 0;
        while (byte_sink_i.got.size() < exp_q.size() && w < 800) begin
            @(posedge clk_sys);
            w++;
        end
        repeat (6) @(posedge clk_sys);
        check("byte count", 16'(byte_sink_i.got.size()), 16'(exp_q.size()));
        check("active format", 16'(active_format), (f == 2'h3) ? 16'h0000 : 16'(f));
        for (int i = 0; i < exp_q.size() && i < byte_sink_i.got.size(); i++)
            check("byte", byte_sink_i.got[i], {i == exp_q.size() - 1, exp_q[i]});
    endtask
    initial begin
        int s;
        rstn = 1'b0;
        format_sel = 2'h0;
        pix_data = 12'h000;
        pix_valid = 1'b0;
        pix_sof = 1'b0;
        pix_eof = 1'b0;
        hold = 1'b0;
        s = $urandom(94);
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int k = 0; k < 14; k++) begin
            for (int i = 0; i < 64; i++) px[i] = 12'($urandom);
            px[0] = 12'hfff;
            px[1] = 12'h000;
            px[2] = 12'h0ff;
            run(2'(k % 4), 3 + $urandom % 20, (k == 5 || k == 6) ? 60 : 0);
        end
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("format after reset", active_format, 2'h0);
        rstn <= 1'b1;
        run(2'h2, 5, 0);
        run(2'h2, 4, 0);
        run(2'h1, 1, 0);
        give_verdict;
    end
endmodule
